// *** hw/rcv_io_pkg.sv ***
// Contract
// - bus switches face the processor only during a read cycle, passing local byte
// - write cycle latches the data byte on the write strobe, driven to local bus
// - low four select-code lines decode into strobes, timed by the write strobe
// - one-shot from NOR of write strobe and inverted select bit five gates strobes
// - serial frequency data is data line zero ANDed with decoder output zero
// - sequencing counter steps on strobes 5,7,11,15; decoder timed by inverted strobe 11 (strobe 5 loads data lines 0-3 instead of stepping)
// - synthesizer serial clock is strobe twelve AND decoder output zero
// - synthesizer load strobe is inverse of decoder output zero
// - beat oscillator data lines load four 8-bit latches addressed by counter bits 1-3
// - beat oscillator latches load on inverted strobe eleven
// - first beat oscillator latch output four enables the beat oscillator synthesizer
// - strobe twelve latches BCD filter code, one-hot slots 2-7, bit four slot 1
// - strobe twelve second latch sets beat oscillator/IF select and AGC dump flip-flop
// - strobe thirteen loads the two AGC mode latches
// - strobe fifteen loads detector, audio level, meter source and five crosspoint lines
// - strobe fourteen loads the eight-bit DAC from all data lines
// - strobe ten loads both optional-card AGC latches
// - out-of-lock input high sets its flag, which lights its fault indicator
// - out-of-lock flags are readable through the addressed bus buffer
// - counter drives two decoders; output five gives rear and front fault levels
// - meter buffer reads comparators on lines 0-2 and option-fitted status on line 4
package rcv_io_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] OFS_CPU_WRITE = 12'h000;
    localparam logic [11:0] OFS_CPU_READ = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;

    // field layout of the write word
    localparam int WR_DATA_LSB = 0;
    localparam int WR_SEL_LSB = 8;
    localparam int SEL_ONESHOT_BIT = 5;
    // field layout of the status word
    localparam int ST_LOCK_LSB = 0;
    localparam int ST_CNT_LSB = 4;
    localparam int ST_BUSY_BIT = 8;
    localparam int ST_DECA_LSB = 12;
    localparam int ST_DECB_LSB = 16;

    // ****************************************
    // strobe numbers, read buffer codes and decoder outputs
    // ****************************************
    localparam logic [3:0] STB_PRESET = 4'h5;
    localparam logic [3:0] STB_SEVEN = 4'h7;
    localparam logic [3:0] STB_OPT_AGC = 4'ha;
    localparam logic [3:0] STB_ELEVEN = 4'hb;
    localparam logic [3:0] STB_TWELVE = 4'hc;
    localparam logic [3:0] STB_AGC = 4'hd;
    localparam logic [3:0] STB_DAC = 4'he;
    localparam logic [3:0] STB_AUDIO = 4'hf;
    localparam int STB_ANALOG_LSB = 10;
    localparam logic [3:0] RD_LOCK = 4'h1;
    localparam logic [3:0] RD_METER = 4'h2;
    localparam logic [3:0] DEC_SYNTH = 4'h0;
    localparam logic [3:0] DEC_FAULT = 4'h5;

    // data line positions
    localparam int FILT_CODE_MSB = 2;
    localparam int FILT_SLOT1_BIT = 4;
    localparam int BEAT_EN_BIT = 4;
    localparam int METER_ISB_BIT = 4;
    localparam int XPT_MSB = 4;
    localparam int AUDIO_MSB = 2;
    localparam int DUMP_BIT = 1;
    localparam int IFSEL_BIT = 0;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int ONESHOT_NS = 200;
    localparam int ONESHOT_CYC = (ONESHOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // serial link to the synthesizer card
    typedef struct packed {
        logic data;
        logic clk;
        logic load_n;
    } synth_link_t;

    // analog card controls
    typedef struct packed {
        logic [6:0] filter_slot;
        logic beat_if_sel;
        logic agc_dump;
        logic [7:0] agc_mode;
        logic [2:0] audio_sw;
        logic [4:0] crosspoint;
        logic [7:0] dac;
        logic [7:0] opt_agc;
    } analog_ctl_t;

endpackage

// *** hw/rcv_io_ctrl.sv ***
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ns
module rcv_io_ctrl
    import rcv_io_pkg::*;
#(
    parameter int ONESHOT_CYCLES = ONESHOT_CYC
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // local status inputs
    input wire logic [7:0] i_panel_data,
    input wire logic [2:0] i_out_of_lock,
    input wire logic [2:0] i_meter_cmp,
    input wire logic i_isb_fitted_n,
    // local bus and strobes
    output logic [7:0] o_local_data,
    output logic o_local_data_oe,
    output logic o_bus_toward_cpu,
    output logic o_write_strobe_n,
    output logic [7:0] o_io_select_code,
    output logic [5:0] o_analog_card_strobes,
    // subsystem controls
    output synth_link_t o_synth,
    output logic [31:0] o_beat_osc_digits,
    output logic o_beat_osc_enable,
    output analog_ctl_t o_analog,
    output logic [2:0] o_lock_led,
    output logic o_fault_rear_n,
    output logic o_fault_front
);

    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rst_sync_q;
    logic rst_n;

    // release through two flops so every flop leaves reset on the same edge
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ****************************************
    // apb slave
    // ****************************************
    logic acc;
    logic rd_sel;
    logic [7:0] data_q;
    logic [7:0] sel_q;
    logic wr_pulse_q;
    logic [2:0] lock_q;
    logic [3:0] count_q;
    logic [3:0] deca_q;
    logic [3:0] decb_q;
    logic [$clog2(ONESHOT_CYCLES+1)-1:0] os_cnt_q;
    logic [7:0] local_rd;

    assign acc = i_psel && i_penable && o_pready;
    assign rd_sel = i_psel && !i_pwrite && (i_paddr == OFS_CPU_READ);

    // byte offered by the addressed local buffer
    always_comb begin
        local_rd = i_panel_data;
        if (sel_q[3:0] == RD_LOCK) begin
            local_rd = {5'b0_0000, lock_q};
        end else if (sel_q[3:0] == RD_METER) begin
            local_rd = 8'h00;
            local_rd[2:0] = i_meter_cmp;
            local_rd[METER_ISB_BIT] = i_isb_fitted_n;
        end
    end

    // one wait state: pready rises the cycle after the access phase starts
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel && i_penable && !o_pready;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
            if (i_psel && i_penable && !o_pready) begin
                case (i_paddr)
                    OFS_CPU_WRITE: begin
                        o_prdata[WR_SEL_LSB +: 8] <= sel_q;
                        o_prdata[WR_DATA_LSB +: 8] <= data_q;
                    end
                    OFS_CPU_READ: begin
                        o_prdata[7:0] <= local_rd;
                    end
                    OFS_STATUS: begin
                        o_prdata[ST_LOCK_LSB +: 3] <= lock_q;
                        o_prdata[ST_CNT_LSB +: 4] <= count_q;
                        o_prdata[ST_BUSY_BIT] <= (os_cnt_q != '0);
                        o_prdata[ST_DECA_LSB +: 4] <= deca_q;
                        o_prdata[ST_DECB_LSB +: 4] <= decb_q;
                    end
                    default: begin
                        o_pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // processor write and read cycles
    // ****************************************
    // write cycle: byte and select code latched, write strobe pulses one cycle
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= 8'h00;
            sel_q <= 8'h00;
            wr_pulse_q <= 1'b0;
        end else begin
            wr_pulse_q <= 1'b0;
            if (acc && i_pwrite && (i_paddr == OFS_CPU_WRITE)) begin
                data_q <= i_pwdata[WR_DATA_LSB +: 8];
                sel_q <= i_pwdata[WR_SEL_LSB +: 8];
                wr_pulse_q <= 1'b1;
            end
        end
    end

    // bus switches turn toward the processor only while a read is open
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_bus_toward_cpu <= 1'b0;
            o_local_data_oe <= 1'b1;
        end else begin
            o_bus_toward_cpu <= rd_sel && !acc;
            o_local_data_oe <= !(rd_sel && !acc);
        end
    end

    // local bus copies of latch, strobe and select code
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_local_data <= 8'h00;
            o_write_strobe_n <= 1'b1;
            o_io_select_code <= 8'h00;
        end else begin
            o_local_data <= data_q;
            o_write_strobe_n <= !wr_pulse_q;
            o_io_select_code <= sel_q;
        end
    end

    // ****************************************
    // strobe decoder and one-shot
    // ****************************************
    logic trig;
    logic [15:0] strobe_q;
    logic [15:0] ld_vec;
    logic [15:0] fall_vec;

    // NOR of the active-low strobe and inverted select bit five
    assign trig = wr_pulse_q && sel_q[SEL_ONESHOT_BIT];
    // load events at strobe rise, clock events at strobe fall
    assign ld_vec = trig ? (16'h0001 << sel_q[3:0]) : 16'h0000;
    assign fall_vec = (os_cnt_q == 1) ? strobe_q : 16'h0000;

    // retrigger is not expected: one select code per write strobe
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            os_cnt_q <= '0;
            strobe_q <= 16'h0000;
        end else if (trig) begin
            os_cnt_q <= ($clog2(ONESHOT_CYCLES+1))'(ONESHOT_CYCLES);
            strobe_q <= ld_vec;
        end else if (os_cnt_q != '0) begin
            os_cnt_q <= os_cnt_q - 1'b1;
            if (os_cnt_q == 1) begin
                strobe_q <= 16'h0000;
            end
        end
    end

    // strobes ten to fifteen go out to the analog cards
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_analog_card_strobes <= 6'b00_0000;
        end else begin
            o_analog_card_strobes <= strobe_q[STB_ANALOG_LSB +: 6];
        end
    end

    // ****************************************
    // sequencing counter and decoders
    // ****************************************
    // NOR of strobes 5,7,11,15 rises as they fall; the counter loads data lines 0-3 at 5 and steps at 7,11,15
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 4'h0;
        end else if (fall_vec[STB_PRESET]) begin
            count_q <= data_q[3:0];
        end else if (fall_vec[STB_SEVEN] || fall_vec[STB_ELEVEN] || fall_vec[STB_AUDIO]) begin
            count_q <= count_q + 4'h1;
        end
    end

    // decoders latch the pre-step count, on the same edge as the counter
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            deca_q <= 4'hf;
            decb_q <= 4'hf;
        end else begin
            if (fall_vec[STB_ELEVEN]) begin
                deca_q <= count_q;
            end
            if (fall_vec[STB_SEVEN]) begin
                decb_q <= count_q;
            end
        end
    end

    // serial link to the synthesizer, fault levels from decoder output five
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_synth <= '{data: 1'b0, clk: 1'b0, load_n: 1'b1};
            o_fault_rear_n <= 1'b1;
            o_fault_front <= 1'b0;
        end else begin
            o_synth.data <= data_q[0] && (deca_q == DEC_SYNTH);
            o_synth.clk <= strobe_q[STB_TWELVE] && (deca_q == DEC_SYNTH);
            o_synth.load_n <= !(deca_q == DEC_SYNTH);
            o_fault_rear_n <= !(decb_q == DEC_FAULT);
            o_fault_front <= (deca_q == DEC_FAULT);
        end
    end

    // ****************************************
    // beat oscillator addressable latches
    // ****************************************
    localparam int BEAT_LINE[4] = '{0, 1, 3, 2};
    logic [31:0] beat_w;

    // each latch takes one data line into the bit addressed by counter bits 1-3
    // each latch owns its byte, so no variable is written from two processes
    generate
        for (genvar k = 0; k < 4; k++) begin : g_beat
            logic [7:0] lat_q;
            always_ff @(posedge i_core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    lat_q <= 8'h00;
                end else if (fall_vec[STB_ELEVEN]) begin
                    lat_q[count_q[3:1]] <= data_q[BEAT_LINE[k]];
                end
            end
            assign beat_w[k*8 +: 8] = lat_q;
        end
    endgenerate

    // digits and synthesizer enable out to the oscillator card
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_beat_osc_digits <= 32'h0000_0000;
            o_beat_osc_enable <= 1'b0;
        end else begin
            o_beat_osc_digits <= beat_w;
            o_beat_osc_enable <= beat_w[BEAT_EN_BIT];
        end
    end

    // ****************************************
    // analog card latches
    // ****************************************
    // latches capture at strobe rise, while the byte is still held
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_analog <= '0;
        end else begin
            if (ld_vec[STB_TWELVE]) begin
                for (int n = 2; n <= 7; n++) begin
                    o_analog.filter_slot[n-1] <= (data_q[FILT_CODE_MSB:0] == 3'(n));
                end
                o_analog.filter_slot[0] <= data_q[FILT_SLOT1_BIT];
                o_analog.beat_if_sel <= data_q[IFSEL_BIT];
                o_analog.agc_dump <= data_q[DUMP_BIT];
            end
            if (ld_vec[STB_AGC]) begin
                o_analog.agc_mode <= data_q;
            end
            if (ld_vec[STB_DAC]) begin
                o_analog.dac <= data_q;
            end
            if (ld_vec[STB_AUDIO]) begin
                o_analog.audio_sw <= data_q[AUDIO_MSB:0];
                o_analog.crosspoint <= data_q[XPT_MSB:0];
            end
            if (ld_vec[STB_OPT_AGC]) begin
                o_analog.opt_agc <= data_q;
            end
        end
    end

    // ****************************************
    // out-of-lock flags
    // ****************************************
    logic lock_clr;
    // reading the buffer clocks the flops with data low; a set input wins
    assign lock_clr = acc && !i_pwrite && (i_paddr == OFS_CPU_READ) && (sel_q[3:0] == RD_LOCK);

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= 3'b000;
            o_lock_led <= 3'b000;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (i_out_of_lock[i]) begin
                    lock_q[i] <= 1'b1;
                end else if (lock_clr) begin
                    lock_q[i] <= 1'b0;
                end
            end
            o_lock_led <= lock_q;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_read_dir: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        o_bus_toward_cpu |-> ($past(rd_sel) && !o_local_data_oe))
        else $error("bus switch faces processor outside a read");
    a_write_latch: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        wr_pulse_q |=> (o_local_data == $past(data_q) && !o_write_strobe_n))
        else $error("written byte not on local bus");
    a_strobe_width: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        trig |=> (strobe_q != 16'h0000) && (os_cnt_q == ONESHOT_CYCLES))
        else $error("one-shot did not open the strobe window");
    a_strobe_onehot: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        $onehot0(strobe_q) && ((strobe_q != 16'h0000) == (os_cnt_q != '0)))
        else $error("strobes not one-hot inside window");
    a_serial_data: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        o_synth.data == ($past(data_q[0]) && $past(deca_q) == DEC_SYNTH))
        else $error("serial data not gated by decoder zero");
    a_serial_clk: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        o_synth.clk == ($past(strobe_q[STB_TWELVE]) && $past(deca_q) == DEC_SYNTH))
        else $error("serial clock wrong");
    a_load_inv: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        o_synth.load_n == ($past(deca_q) != DEC_SYNTH))
        else $error("load strobe not inverse of decoder zero");
    a_counter_step: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        (fall_vec[STB_ELEVEN] && !fall_vec[STB_PRESET]) |=> (count_q == $past(count_q) + 4'h1))
        else $error("counter did not step on strobe eleven");
    a_dac_load: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        ld_vec[STB_DAC] |=> (o_analog.dac == $past(data_q)))
        else $error("dac not loaded on strobe fourteen");
    a_lock_set: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_out_of_lock[0] |=> lock_q[0] ##1 o_lock_led[0])
        else $error("out-of-lock flag or indicator not set");
    a_filter_load: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        ld_vec[STB_TWELVE] |=> (o_analog.filter_slot[0] == $past(data_q[FILT_SLOT1_BIT])))
        else $error("filter slot one not taken from line four");
    a_opt_agc_load: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        ld_vec[STB_OPT_AGC] |=> (o_analog.opt_agc == $past(data_q)))
        else $error("optional agc latches not loaded on strobe ten");
    a_beat_enable: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        o_beat_osc_enable == $past(beat_w[BEAT_EN_BIT]))
        else $error("beat oscillator enable not from first latch bit four");

endmodule

// *** verif/rcv_subsys_model.sv ***
`timescale 1ns/1ns
// ****************************************
// receiver subsystems seen from the io card
// ****************************************
module rcv_subsys_model (
    // controls from the bench
    input wire logic [2:0] i_unlock,
    input wire logic i_card_present,
    input wire logic [2:0] i_cmp_lvl,
    input wire logic [7:0] i_keys,
    // lines into the io card
    output logic [2:0] o_out_of_lock,
    output logic [2:0] o_meter_cmp,
    output logic o_isb_fitted_n,
    output logic [7:0] o_panel_data
);
    // a loop that loses lock drives its line high until it relocks
    assign o_out_of_lock = i_unlock;
    // fitted line idles high on its pull-up, the option card grounds it
    assign o_isb_fitted_n = ~i_card_present;
    assign o_meter_cmp = i_cmp_lvl;
    // key lines sit high on pull-ups, a pressed key reads low
    assign o_panel_data = ~i_keys;
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    import rcv_io_pkg::*;
    localparam int OS = 3;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, err, tow, oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, digits;
    logic [2:0] unlock, cmp, lost, mcmp, led;
    logic card, isbn, wsn, beat_en, rear_n, front, ldoe, btc;
    logic [7:0] keys, pdata, ldata, selc;
    logic [5:0] stb;
    synth_link_t synth;
    analog_ctl_t ana;
    int n_errors, compares, cyc, sclk;

    // ****************************************
    // design and far side
    // ****************************************
    rcv_io_ctrl #(.ONESHOT_CYCLES(OS)) i_rcv_io_ctrl (
        .i_core_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_panel_data(pdata),
        .i_out_of_lock(lost), .i_meter_cmp(mcmp), .i_isb_fitted_n(isbn),
        .o_local_data(ldata), .o_local_data_oe(ldoe), .o_bus_toward_cpu(btc),
        .o_write_strobe_n(wsn), .o_io_select_code(selc), .o_analog_card_strobes(stb),
        .o_synth(synth), .o_beat_osc_digits(digits), .o_beat_osc_enable(beat_en),
        .o_analog(ana), .o_lock_led(led), .o_fault_rear_n(rear_n), .o_fault_front(front)
    );
    rcv_subsys_model i_rcv_subsys_model (
        .i_unlock(unlock), .i_card_present(card), .i_cmp_lvl(cmp), .i_keys(keys),
        .o_out_of_lock(lost), .o_meter_cmp(mcmp), .o_isb_fitted_n(isbn),
        .o_panel_data(pdata)
    );

    // 50 mhz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // cuts a hang short well past the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            finish_test;
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        // ends when pready is sampled high; only the bench timeout ends a hang
        while (pready !== 1'b1) begin
            @(posedge clk);
            i++;
        end
        chk(i, 2);
        rd = prdata;
        err = pslverr;
        tow = btc;
        oe = ldoe;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // write one select code and byte, then watch the strobe window close
    task automatic wr(input logic [7:0] s, input logic [7:0] d);
        logic [5:0] m;
        int i, lo, hi, oth, sc;
        m = (s[5] && s[3:0] >= 4'ha) ? 6'h01 << (s[3:0] - 4'ha) : 6'h00;
        lo = 0;
        hi = 0;
        oth = 0;
        sc = 0;
        apb(1'b1, OFS_CPU_WRITE, {16'h0000, s, d});
        for (i = 0; i < OS + 8; i++) begin
            @(posedge clk);
            lo += (wsn === 1'b0);
            hi += (m != 0 && stb === m);
            oth += ((stb & ~m) != 0);
            sc += (synth.clk === 1'b1);
        end
        chk(lo, 1);
        chk(hi, m != 0 ? OS : 0);
        chk(oth, 0);
        chk({selc, ldata}, {s, d});
        sclk = sc;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_beat;
        wr(8'h25, 8'h02);
        apb(1'b0, OFS_STATUS, 0);
        chk(rd[7:4], 4'h2);
        wr(8'h2b, 8'h0f);
        chk(digits, 32'h0202_0202);
        apb(1'b0, OFS_STATUS, 0);
        chk(rd[7:4], 4'h3);
        wr(8'h25, 8'h08);
        wr(8'h2b, 8'h01);
        chk(digits, 32'h0202_0212);
        chk(beat_en, 1'b1);
    endtask

    task automatic t_fault;
        wr(8'h25, 8'h05);
        wr(8'h27, 8'h00);
        chk({rear_n, front}, 2'h0);
        wr(8'h25, 8'h05);
        wr(8'h2b, 8'h00);
        chk(front, 1'b1);
    endtask

    task automatic t_synth;
        wr(8'h25, 8'h00);
        wr(8'h2b, 8'h01);
        chk({synth.load_n, synth.data}, 2'h1);
        wr(8'h2c, 8'h01);
        chk(sclk, OS);
        wr(8'h25, 8'h03);
        wr(8'h2b, 8'h00);
        chk({synth.load_n, synth.data}, 2'h2);
        wr(8'h2c, 8'h01);
        chk(sclk, 0);
    endtask

    task automatic t_analog;
        logic [7:0] n;
        for (n = 8'h02; n < 8'h08; n++) begin
            wr(8'h2c, n);
            chk(ana.filter_slot, 7'h01 << (n - 1));
        end
        wr(8'h2c, 8'h13);
        chk({ana.filter_slot, ana.beat_if_sel, ana.agc_dump}, 9'h017);
        wr(8'h0c, 8'h07);
        chk(ana.filter_slot, 7'h05);
        wr(8'h2d, 8'ha5);
        chk(ana.agc_mode, 8'ha5);
        wr(8'h2e, 8'h3c);
        chk(ana.dac, 8'h3c);
        wr(8'h2f, 8'h16);
        chk({ana.audio_sw, ana.crosspoint}, 8'hd6);
        wr(8'h2a, 8'h5a);
        chk(ana.opt_agc, 8'h5a);
    endtask

    task automatic t_ool;
        unlock <= 3'h5;
        @(posedge clk);
        unlock <= 3'h0;
        repeat (4) @(posedge clk);
        chk(led, 3'h5);
        wr(8'h01, 8'h00);
        apb(1'b0, OFS_CPU_READ, 0);
        chk(rd, 32'h0000_0005);
        chk({tow, oe}, 2'h2);
        apb(1'b0, OFS_CPU_READ, 0);
        chk(rd, 32'h0000_0000);
    endtask

    task automatic t_meter;
        cmp <= 3'h3;
        wr(8'h02, 8'h00);
        apb(1'b0, OFS_CPU_READ, 0);
        chk(rd, 32'h0000_0013);
        card <= 1'b1;
        apb(1'b0, OFS_CPU_READ, 0);
        chk(rd, 32'h0000_0003);
        wr(8'h03, 8'h00);
        apb(1'b0, OFS_CPU_READ, 0);
        chk(rd, {24'h00_0000, ~keys});
        apb(1'b0, 12'h00c, 0);
        chk(err, 1'b1);
        chk(rd, 32'h0000_0000);
    endtask

    task automatic finish_test;
        if (n_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        unlock = 3'h0;
        cmp = 3'h0;
        card = 1'b0;
        keys = 8'h5a;
        n_errors = 0;
        compares = 0;
        cyc = 0;
        repeat (4) @(posedge clk);
        chk({ldoe, wsn, synth.load_n, rear_n, front, stb, led}, 14'h3c00);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_beat;
        t_fault;
        t_synth;
        t_analog;
        t_ool;
        t_meter;
        finish_test;
    end
endmodule
